// *** hdl/mcsc_consts.vh ***
// Purpose: constants for the system control register block
// Assumes: 8-bit data bus, 200 MHz cpu clock
// Notes: header only, definitions
`ifndef MCSC_CONSTS_VH
`define MCSC_CONSTS_VH
// ****************************************
// addresses
// ****************************************
`define MCSC_DATA_ADDR 16'h0055
`define MCSC_IO_OFFSET 16'h0020
`define MCSC_IO_ADDR 6'h35
`define MCSC_EXT_IO_BASE 16'h0060
// ****************************************
// field positions
// ****************************************
`define MCSC_BIT_DBG_DIS 7
`define MCSC_BIT_BOD_OFF 6
`define MCSC_BIT_BOD_UNL 5
`define MCSC_BIT_PU_OFF 4
`define MCSC_BIT_VSEL 1
`define MCSC_BIT_VUNL 0
`define MCSC_IMPL_MASK 8'hF3
`define MCSC_RESET_VAL 8'h00
// ****************************************
// timing counts in cycles
// ****************************************
`define MCSC_UNLOCK_CYC 3'h4
`define MCSC_BOD_ACT_CYC 3'h3
`define MCSC_BOD_CLR_CYC 3'h3
`define MCSC_CNT_W 3
`endif

// *** hdl/mcsc_window.v ***
// Purpose: timed unlock window counter
// Assumes: one clock, synchronous reset copy in
// Notes: restart reopens the window for a fixed number of cycles
`timescale 1ns/1ps
`default_nettype none
`include "mcsc_consts.vh"
module mcsc_window #(
  parameter [`MCSC_CNT_W-1:0] LEN = `MCSC_UNLOCK_CYC
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // control
  input wire restart,
  input wire close,
  // state
  output wire open,
  output wire [`MCSC_CNT_W-1:0] left
);
  // remaining cycles of the window
  reg [`MCSC_CNT_W-1:0] cnt;
  assign open = (cnt != {`MCSC_CNT_W{1'b0}});
  assign left = cnt;
  // ****************************************
  // counter
  // ****************************************
  // restart beats close, close beats count down
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= {`MCSC_CNT_W{1'b0}};
    end else if (ce) begin
      if (restart) begin
        cnt <= LEN;
      end else if (close) begin
        cnt <= {`MCSC_CNT_W{1'b0}};
      end else if (open) begin
        cnt <= cnt - {{(`MCSC_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// *** hdl/mcsc_control.v ***
// Purpose: system control register with timed unlock sequences
// Assumes: cpu writes with one-cycle strobes, io or data address space
// Notes: vector table, sleep control, detector and pins live elsewhere
// Behaviour
// - debug port on when fuse on and not disabled
// - debug disable changes only on matching double write
// - brownout sleep off needs unlock-then-set order
// - brownout sleep off active after three, clears
// - detector off only if sleep while active
// - global pull-up off overrides pin configuration
// - vector select picks flash start or boot
// - vector select changes only via unlock sequence
// - interrupts blocked during vector change sequence
// - blocking leaves global interrupt flag untouched
// - vector unlock self-clears after four or select
// - boot vectors plus app lock block app
// - app vectors plus boot lock block boot
// - register at data 0x55 and io 0x35
// - extended io space only by data access
// - boot vector address adds boot section start
// - boot reset fuse moves reset address
`timescale 1ns/1ps
`default_nettype none
`include "mcsc_consts.vh"
module mcsc_control (
  // clock and reset
  input wire clk,
  input wire rstn,
  input wire ce,
  // io-space access (short instructions)
  input wire io_wr,
  input wire io_rd,
  input wire [5:0] io_addr,
  // data-space access (load and store)
  input wire ds_wr,
  input wire ds_rd,
  input wire [15:0] ds_addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata,
  // cpu status
  input wire instr_done,
  input wire sleep_exec,
  input wire global_interrupt_flag,
  input wire exec_in_boot,
  // fuses and lock bits
  input wire debug_port_fuse_on,
  input wire boot_reset_fuse,
  input wire app_section_lock_bit,
  input wire boot_section_lock_bit,
  input wire [15:0] boot_start_addr,
  // vector lookup
  input wire [15:0] vector_offset,
  output reg [15:0] vector_addr,
  output reg [15:0] reset_addr,
  // control outputs
  output reg [7:0] mcu_system_control,
  output wire debug_port_enable,
  output wire pullup_global_off,
  output wire brownout_sleep_off_active,
  output reg brownout_detector_sleep_off,
  output wire irq_allow
);
  // ****************************************
  // reset synchroniser
  // ****************************************
  reg rst_s1;
  reg rst_n;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end
  // ****************************************
  // address decode
  // ****************************************
  // short io reaches only 0x00-0x3F, i.e. data 0x20-0x5F
  wire hit_io = (io_addr == `MCSC_IO_ADDR);
  wire hit_ds = (ds_addr == `MCSC_DATA_ADDR);
  wire wr = ((io_wr && hit_io) || (ds_wr && hit_ds)) && ce;
  wire rd = (io_rd && hit_io) || (ds_rd && hit_ds);
  // write fields
  wire w_dbg = wdata[`MCSC_BIT_DBG_DIS];
  wire w_bod = wdata[`MCSC_BIT_BOD_OFF];
  wire w_bodu = wdata[`MCSC_BIT_BOD_UNL];
  wire w_vsel = wdata[`MCSC_BIT_VSEL];
  wire w_vunl = wdata[`MCSC_BIT_VUNL];
  // ****************************************
  // unlock windows
  // ****************************************
  // debug disable: first write arms with its value
  reg dbg_pend;
  wire dbg_open;
  wire dbg_match = wr && dbg_open && (w_dbg == dbg_pend);
  wire dbg_start = wr && !dbg_match;
  mcsc_window u_dbg_win (.clk(clk), .rst_n(rst_n), .ce(ce),
    .restart(dbg_start), .close(dbg_match), .open(dbg_open), .left());
  // brownout unlock
  wire bod_open;
  wire [`MCSC_CNT_W-1:0] bod_left; // cycles left in the brownout window
  wire bod_arm = wr && w_bod && w_bodu;
  wire bod_set = wr && bod_open && w_bod && !w_bodu;
  mcsc_window u_bod_win (.clk(clk), .rst_n(rst_n), .ce(ce),
    .restart(bod_arm), .close(bod_set), .open(bod_open), .left(bod_left));
  // vector unlock
  wire vec_open;
  wire [`MCSC_CNT_W-1:0] vec_left; // cycles left in the vector window
  wire vec_arm = wr && w_vunl;
  wire vec_set = wr && vec_open && !w_vunl;
  mcsc_window u_vec_win (.clk(clk), .rst_n(rst_n), .ce(ce),
    .restart(vec_arm), .close(vec_set), .open(vec_open), .left(vec_left));
  // ****************************************
  // brownout sleep state machine
  // ****************************************
  localparam [2:0] BS_IDLE = 3'h1;
  localparam [2:0] BS_WAIT = 3'h2;
  localparam [2:0] BS_ACT = 3'h4;
  reg [2:0] bs_state;
  reg [2:0] next_bs_state;
  reg [2:0] bs_cnt;
  // next state
  always @* begin
    next_bs_state = bs_state;
    case (bs_state)
      BS_IDLE: begin
        if (bod_set) begin
          next_bs_state = BS_WAIT;
        end
      end
      BS_WAIT: begin
        if (bs_cnt == `MCSC_BOD_ACT_CYC - 3'h1) begin
          next_bs_state = BS_ACT;
        end
      end
      BS_ACT: begin
        if (bs_cnt == `MCSC_BOD_CLR_CYC - 3'h1) begin
          next_bs_state = BS_IDLE;
        end
      end
      default: begin
        next_bs_state = BS_IDLE;
      end
    endcase
  end
  // state and phase counter
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bs_state <= BS_IDLE;
      bs_cnt <= 3'h0;
    end else if (ce) begin
      bs_state <= next_bs_state;
      if (next_bs_state != bs_state) begin
        bs_cnt <= 3'h0;
      end else if (bs_state != BS_IDLE) begin
        bs_cnt <= bs_cnt + 3'h1;
      end
    end
  end
  assign brownout_sleep_off_active = (bs_state == BS_ACT);
  // ****************************************
  // control register
  // ****************************************
  // register storage, unused bits stay zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mcu_system_control <= `MCSC_RESET_VAL;
      dbg_pend <= 1'b0;
    end else if (ce) begin
      if (dbg_start) begin
        dbg_pend <= w_dbg;
      end
      if (dbg_match) begin
        mcu_system_control[`MCSC_BIT_DBG_DIS] <= w_dbg;
      end
      if (wr) begin
        mcu_system_control[`MCSC_BIT_PU_OFF] <= wdata[`MCSC_BIT_PU_OFF];
      end
      // brownout bit reads set from set write until auto clear
      mcu_system_control[`MCSC_BIT_BOD_OFF] <= (next_bs_state != BS_IDLE);
      mcu_system_control[`MCSC_BIT_BOD_UNL] <= (bod_arm || bod_open) && !bod_set
        && !(bod_open && bod_left == 3'h1 && !bod_arm);
      if (vec_set) begin
        mcu_system_control[`MCSC_BIT_VSEL] <= w_vsel;
      end
      // unlock bit self clears with its window
      mcu_system_control[`MCSC_BIT_VUNL] <= vec_arm ||
        (vec_open && !vec_set && vec_left != 3'h1);
    end
  end
  // read data from flip-flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= rd ? (mcu_system_control & `MCSC_IMPL_MASK) : 8'h00;
    end
  end
  // ****************************************
  // interrupt blocking
  // ****************************************
  // after select write, hold off until next instruction completes
  reg vec_tail;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_tail <= 1'b0;
    end else if (ce) begin
      if (vec_set) begin
        vec_tail <= 1'b1;
      end else if (instr_done) begin
        vec_tail <= 1'b0;
      end
    end
  end
  wire vsel = mcu_system_control[`MCSC_BIT_VSEL];
  wire lock_blk = (vsel && app_section_lock_bit && !exec_in_boot) ||
    (!vsel && boot_section_lock_bit && exec_in_boot);
  // global flag itself is never written here
  assign irq_allow = global_interrupt_flag && !vec_arm && !vec_open && !vec_tail && !lock_blk;
  // ****************************************
  // outputs
  // ****************************************
  assign debug_port_enable = debug_port_fuse_on && !mcu_system_control[`MCSC_BIT_DBG_DIS];
  assign pullup_global_off = mcu_system_control[`MCSC_BIT_PU_OFF];
  // vector and reset addresses, detector latch
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_addr <= 16'h0000;
      reset_addr <= 16'h0000;
      brownout_detector_sleep_off <= 1'b0;
    end else if (ce) begin
      vector_addr <= vsel ? (boot_start_addr + vector_offset) : vector_offset;
      reset_addr <= boot_reset_fuse ? boot_start_addr : 16'h0000;
      if (sleep_exec) begin
        brownout_detector_sleep_off <= brownout_sleep_off_active;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/mcsc_control_asserts.sv ***
// Purpose: concurrent checks on the system control register ports
// Assumes: clock enable held high while these are evaluated
// Notes: attached by bind from the bench top
`timescale 1ns/1ps
`default_nettype none
module mcsc_control_chk (
  // clock and reset
  input wire clk,
  input wire rstn,
  // cpu side
  input wire io_wr,
  input wire ds_wr,
  input wire sleep_exec,
  input wire global_interrupt_flag,
  input wire debug_port_fuse_on,
  // register and derived outputs
  input wire [7:0] mcu_system_control,
  input wire debug_port_enable,
  input wire pullup_global_off,
  input wire brownout_sleep_off_active,
  input wire brownout_detector_sleep_off,
  input wire irq_allow
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // detector-off request waits three cycles, then stands for three
  sequence s_bod_wait; !brownout_sleep_off_active [*3]; endsequence
  sequence s_bod_on; brownout_sleep_off_active [*3] ##1 !brownout_sleep_off_active; endsequence
  a_debug_enable_map: assert property (rstn && $past(rstn, 3) |->
    debug_port_enable == (debug_port_fuse_on && !mcu_system_control[7])) else $error("debug enable wrong");
  a_pullup_bit_map: assert property (pullup_global_off == mcu_system_control[4])
    else $error("pull-up off output differs from its bit");
  a_unused_bits_zero: assert property (mcu_system_control[3:2] == 2'b00)
    else $error("unused bits not zero");
  a_debug_needs_write: assert property ($changed(mcu_system_control[7]) |-> $past(io_wr || ds_wr))
    else $error("debug disable changed without a write");
  a_unlock_self_clear: assert property ($rose(mcu_system_control[0]) |-> ##[1:4] !mcu_system_control[0])
    else $error("vector unlock stayed set too long");
  a_unlock_blocks_irq: assert property (mcu_system_control[0] |-> !irq_allow)
    else $error("interrupt allowed while vector unlock open");
  a_flag_gates_irq: assert property (!global_interrupt_flag |-> !irq_allow)
    else $error("interrupt allowed with flag clear");
  a_bod_active_window: assert property ($rose(mcu_system_control[6]) |-> s_bod_wait ##1 s_bod_on)
    else $error("brownout sleep off active window wrong");
  a_sleep_turns_off: assert property (sleep_exec && brownout_sleep_off_active |=> brownout_detector_sleep_off)
    else $error("detector not switched off on sleep");
endmodule
`default_nettype wire

// *** verif/test_mcu_control_timed_register.sv ***
// Purpose: self-checking bench for the system control register
// Assumes: clock enable tied high, inputs move on the falling edge
// Notes: vector base and boot start are fixed levels
`timescale 1ns/1ps
`default_nettype none
module test_mcu_control_timed_register;
  // ****************************************
  // stimulus, instance and tasks
  // ****************************************
  logic clk = 1'b0, rstn = 1'b0, io_wr = 1'b0, io_rd = 1'b0, ds_wr = 1'b0, ds_rd = 1'b0;
  logic [5:0] io_addr = 6'h00;
  logic [15:0] ds_addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic instr_done = 1'b0, sleep_exec = 1'b0, gif = 1'b1, in_boot = 1'b0;
  logic fuse_dbg = 1'b1, fuse_rst = 1'b0, lock_app = 1'b0, lock_boot = 1'b0;
  wire [7:0] rdata, mcsc;
  wire [15:0] vec_addr, rst_addr;
  wire dbg_en, pu_off, bod_act, bod_det, irq_ok;
  int fail_count = 0;
  int n_checks = 0;
  mcsc_control u_mcsc_control (.clk(clk), .rstn(rstn), .ce(1'b1), .io_wr(io_wr), .io_rd(io_rd),
    .io_addr(io_addr), .ds_wr(ds_wr), .ds_rd(ds_rd), .ds_addr(ds_addr), .wdata(wdata), .rdata(rdata),
    .instr_done(instr_done), .sleep_exec(sleep_exec), .global_interrupt_flag(gif), .exec_in_boot(in_boot),
    .debug_port_fuse_on(fuse_dbg), .boot_reset_fuse(fuse_rst), .app_section_lock_bit(lock_app),
    .boot_section_lock_bit(lock_boot), .boot_start_addr(16'h7000), .vector_offset(16'h0004),
    .vector_addr(vec_addr), .reset_addr(rst_addr), .mcu_system_control(mcsc), .debug_port_enable(dbg_en),
    .pullup_global_off(pu_off), .brownout_sleep_off_active(bod_act), .brownout_detector_sleep_off(bod_det),
    .irq_allow(irq_ok));
  // compare and count
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one write strobe, data space when ds is set
  task automatic wr(input bit ds, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a[5:0];
    ds_addr = a;
    wdata = d;
    io_wr = !ds;
    ds_wr = ds;
    @(negedge clk);
    io_wr = 1'b0;
    ds_wr = 1'b0;
  endtask
  // one read strobe, data valid the cycle after
  task automatic rd(input bit ds, input logic [7:0] exp);
    @(negedge clk);
    io_addr = 6'h35;
    ds_addr = 16'h0055;
    io_rd = !ds;
    ds_rd = ds;
    @(negedge clk);
    io_rd = 1'b0;
    ds_rd = 1'b0;
    chk("register", rdata, exp);
  endtask
  // one-cycle pulse of sleep or instruction done
  task automatic pulse(input bit slp);
    @(negedge clk);
    sleep_exec = slp;
    instr_done = !slp;
    @(negedge clk);
    sleep_exec = 1'b0;
    instr_done = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // clock and watchdog
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    #20000;
    fail_count++;
    wrap_up;
  end
  // main sequence
  initial begin
    idle(5);
    rstn = 1'b1;
    idle(3);
    rd(0, 8'h00);
    chk("debug enable", dbg_en, 1'b1);
    chk("reset address", rst_addr, 16'h0000);
    $display("test reset done");
    wr(0, 16'h0035, 8'h90);
    idle(8);
    rd(0, 8'h10);
    wr(1, 16'h0055, 8'h9C); // no on-chip debug session runs while this bit moves
    wr(0, 16'h0035, 8'h9C);
    rd(1, 8'h90);
    chk("debug enable", dbg_en, 1'b0);
    chk("pull-up off", pu_off, 1'b1);
    wr(1, 16'h0075, 8'h00);
    wr(1, 16'h0075, 8'h00);
    wr(1, 16'h0035, 8'h00);
    wr(1, 16'h0035, 8'h00);
    wr(0, 16'h0015, 8'h00);
    rd(0, 8'h90);
    $display("test debug and decode done");
    wr(0, 16'h0035, 8'hD0);
    pulse(1);
    rd(0, 8'h90);
    chk("detector off", bod_det, 1'b0);
    wr(0, 16'h0035, 8'hF0);
    wr(0, 16'h0035, 8'hD0);
    idle(4);
    pulse(1);
    chk("detector off", bod_det, 1'b1);
    idle(8);
    rd(0, 8'h90);
    $display("test brownout done");
    wr(0, 16'h0035, 8'h91);
    chk("irq allow", irq_ok, 1'b0);
    wr(0, 16'h0035, 8'h92);
    chk("register", mcsc, 8'h92);
    pulse(0);
    pulse(0);
    chk("irq allow", irq_ok, 1'b1);
    chk("vector address", vec_addr, 16'h7004);
    wr(0, 16'h0035, 8'h90);
    wr(0, 16'h0035, 8'h91);
    idle(6);
    chk("register", mcsc, 8'h92);
    chk("irq allow", irq_ok, 1'b1);
    lock_app = 1'b1;
    idle(2);
    chk("irq allow", irq_ok, 1'b0);
    in_boot = 1'b1;
    idle(2);
    chk("irq allow", irq_ok, 1'b1);
    lock_app = 1'b0;
    wr(0, 16'h0035, 8'h91);
    wr(0, 16'h0035, 8'h90);
    pulse(0);
    pulse(0);
    chk("vector address", vec_addr, 16'h0004);
    lock_boot = 1'b1;
    fuse_rst = 1'b1;
    idle(2);
    chk("irq allow", irq_ok, 1'b0);
    chk("reset address", rst_addr, 16'h7000);
    $display("test vectors done");
    wrap_up;
  end
endmodule
bind mcsc_control mcsc_control_chk u_chk (.clk(clk), .rstn(rstn), .io_wr(io_wr), .ds_wr(ds_wr),
  .sleep_exec(sleep_exec), .global_interrupt_flag(global_interrupt_flag), .debug_port_fuse_on(debug_port_fuse_on),
  .mcu_system_control(mcu_system_control), .debug_port_enable(debug_port_enable),
  .pullup_global_off(pullup_global_off), .brownout_sleep_off_active(brownout_sleep_off_active),
  .brownout_detector_sleep_off(brownout_detector_sleep_off), .irq_allow(irq_allow));
`default_nettype wire
